// >>> logic/fjs_pkg.sv
/*
  Constants for the fastening job sequencer: register offsets, field
  positions, reset values and timing counts.
  Assumes a 125 MHz system clock and an 8-bit byte address register port.
*/
package fjs_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int JOBS     = 99;
  localparam int STEPS    = 30;
  localparam int STAGES   = 8;
  localparam int CHANNELS = 99;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint CLK_HZ     = 125000000;
  localparam longint SEC_NS     = 1000000000;
  localparam longint MSEC_NS    = 1000000;
  localparam longint CLK_NS     = SEC_NS / CLK_HZ;
  localparam int     SEC_CYC    = int'(SEC_NS / CLK_NS);
  localparam int     MSEC_CYC   = int'(MSEC_NS / CLK_NS);

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_BATCH  = 8'h04;
  localparam logic [7:0] A_RECORD = 8'h08;
  localparam logic [7:0] A_PAUSE  = 8'h0c;
  localparam logic [7:0] A_STG_LO = 8'h10;
  localparam logic [7:0] A_STG_HI = 8'h14;
  localparam logic [7:0] A_JADDR  = 8'h18;
  localparam logic [7:0] A_JSTEP  = 8'h1c;
  localparam logic [7:0] A_JTIME  = 8'h20;
  localparam logic [7:0] A_JFLAG  = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;
  localparam logic [7:0] A_DOUT0  = 8'h2c;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int C_PSEL  = 7;
  localparam int C_MULTI = 8;
  localparam int C_BALL  = 9;
  localparam int C_SRC   = 10;
  localparam int C_BLOCK = 12;
  localparam int C_PAUSE = 13;
  localparam logic [1:0] SRC_OFF  = 2'h0;
  localparam logic [1:0] SRC_CHAN = 2'h1;

  // ****************************************
  // Per-job flag fields
  // ****************************************
  localparam int F_TALLY  = 0;
  localparam int F_GATE   = 1;
  localparam int F_REPEAT = 2;
  localparam int F_LOOSE  = 3;
  localparam int F_CONT   = 5;
  localparam int F_LOCK   = 6;
  localparam logic [1:0] LOOSE_DIS  = 2'h1;
  localparam logic [1:0] LOOSE_FAIL = 2'h2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [6:0]  TGT_RST   = 7'h01;
  localparam logic [7:0]  CURVE_RST = 8'hff;
  localparam logic [7:0]  FLAG_RST  = 8'h40;
endpackage

// >>> logic/fastening_job_sequencer.sv
/*
  Fastening job sequencer: job table, step walk, stage walk, tallies,
  batch judgment, timeouts, launch gate, repeat, loosening and tool lock.
  Assumes a fastening engine on clk_sys (start pulse out, done pulse with
  judgment in) and asynchronous panel/PLC pins, synchronised here except target bits 6:1.
*/
// Local design decisions: the address map and strobed register access.
// Behaviour
// - Batch tally counts good or every judgment
// - Target reached all good: lamp, good output
// - Target reached with bad: fail output
// - Programmed target used when source is channel
// - Batch lock blocks tool after count when multi is set
// - Optional idle wait between stages
// - Record selected stage; zero means final
// - Curve captured only on enabled stages; without multi the code ignores the enables and always captures
// - Result sent when channel output enabled
// - 99 jobs, 30 steps each
// - Job number from panel or port
// - Steps run until zero channel or count
// - Launch timeout invalidates and ends job
// - Completion timeout blocks remaining steps
// - Step tally counts good or every judgment
// - Launch gate waits for launch input
// - Repeat lets completed job run again
// - Reverse disabled ignores reverse requests
// - After fail, loosen before next step
// - Continuous run needs one start only
// - No continuous run with multi-spindle
// - Hold-off ignores start until release
// - Up to eight stages, zero ends list
`timescale 1ns/1ps
module fastening_job_sequencer
  import fjs_pkg::*;
#(
  parameter int SEC_CYCLES  = SEC_CYC,
  parameter int MSEC_CYCLES = MSEC_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Panel and PLC pins
  input  wire logic [6:0]  ext_job_num,
  input  wire logic        start_in,
  input  wire logic        seq_launch_in,
  input  wire logic        run_in,
  input  wire logic        reset_in,
  input  wire logic        tool_reset_in,
  input  wire logic        id_reentry_in,
  input  wire logic        reverse_req_in,
  input  wire logic        multi_spindle_in,
  input  wire logic [6:0]  batch_target_ext,
  // Fastening engine
  output logic             engine_start,
  output logic [6:0]       engine_channel,
  output logic             reverse_cmd,
  input  wire logic        fasten_done,
  input  wire logic        fasten_good,
  input  wire logic        loosen_done,
  // Results and lamps
  output logic             batch_good_output,
  output logic             batch_good_lamp,
  output logic             batch_fail_output,
  output logic             curve_capture,
  output logic             data_out_req,
  output logic [7:0]       record_strobe,
  output logic             job_done,
  output logic             job_invalid,
  output logic             job_blocked
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NP = 16;
  logic [NP-1:0] pin_raw, s1_reg, s2_reg, s3_reg, pin_reg, pin_prev_reg;
  assign pin_raw = {batch_target_ext[0], multi_spindle_in, reverse_req_in,
                    id_reentry_in, tool_reset_in, reset_in, run_in,
                    seq_launch_in, start_in, ext_job_num};
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      // A change counts only once the last two stages agree
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          s1_reg[gi]  <= 1'b0;
          s2_reg[gi]  <= 1'b0;
          s3_reg[gi]  <= 1'b0;
          pin_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) pin_reg[gi] <= s3_reg[gi];
        end
      end
    end
  endgenerate
  // Only target bit 0 is synchronised, in the shared vector; bits 6:1
  // are taken raw and are held static by the PLC while a batch runs.
  logic [6:0] tgt_ext;
  assign tgt_ext = {batch_target_ext[6:1], pin_reg[15]};
  wire [NP-1:0] rise = pin_reg & ~pin_prev_reg;
  wire       start_evt  = rise[7];
  wire       launch_evt = rise[8];
  wire       release_evt = rise[9] | rise[10] | rise[11] | rise[12] | launch_evt;
  wire       rev_lvl    = pin_reg[13];
  wire       mspindle   = pin_reg[14];

  // ****************************************
  // Registers and tables
  // ****************************************
  logic [31:0] ctrl_reg, record_reg, pause_reg, stg_lo_reg, stg_hi_reg;
  logic [6:0]  tgt_reg;
  logic [7:0]  curve_reg;
  logic [6:0]  ja_job_reg;
  logic [4:0]  ja_step_reg;
  logic [127:0] dout_en_reg;
  logic [13:0] job_mem  [0:JOBS*STEPS-1];
  logic [27:0] time_mem [0:JOBS-1];
  logic [7:0]  flag_mem [0:JOBS-1];

  wire [11:0] wr_idx = 12'(ja_job_reg) * 12'(STEPS) + 12'(ja_step_reg);
  wire        ja_ok  = ja_job_reg < 7'(JOBS) && ja_step_reg < 5'(STEPS);
  wire        we_ctrl = reg_wr && reg_addr == A_CTRL;
  wire        we_bat  = reg_wr && reg_addr == A_BATCH;
  wire        we_step = reg_wr && reg_addr == A_JSTEP && ja_ok;
  wire        we_time = reg_wr && reg_addr == A_JTIME && ja_ok;
  wire        we_flag = reg_wr && reg_addr == A_JFLAG && ja_ok;
  wire [1:0]  dout_w  = 2'((reg_addr - A_DOUT0) >> 2);
  wire        dout_hit = reg_addr >= A_DOUT0 && reg_addr <= A_DOUT0 + 8'h0c;

  always_ff @(posedge clk_sys) begin
    if (we_step) job_mem[wr_idx] <= reg_wdata[13:0];
    if (we_time) time_mem[ja_job_reg] <= reg_wdata[27:0];
    if (we_flag) flag_mem[ja_job_reg] <= reg_wdata[7:0];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_reg    <= CTRL_RST;
      tgt_reg     <= TGT_RST;
      curve_reg   <= CURVE_RST;
      record_reg  <= '0;
      pause_reg   <= '0;
      stg_lo_reg  <= '0;
      stg_hi_reg  <= '0;
      ja_job_reg  <= '0;
      ja_step_reg <= '0;
      dout_en_reg <= '0;
    end else if (reg_wr) begin
      if (we_ctrl) ctrl_reg <= reg_wdata;
      if (we_bat) tgt_reg <= reg_wdata[6:0];
      if (we_bat) curve_reg <= reg_wdata[15:8];
      if (reg_addr == A_RECORD) record_reg <= reg_wdata;
      if (reg_addr == A_PAUSE) pause_reg <= reg_wdata;
      if (reg_addr == A_STG_LO) stg_lo_reg <= reg_wdata;
      if (reg_addr == A_STG_HI) stg_hi_reg <= reg_wdata;
      if (reg_addr == A_JADDR) ja_job_reg <= reg_wdata[6:0];
      if (reg_addr == A_JADDR) ja_step_reg <= reg_wdata[12:8];
      if (dout_hit) dout_en_reg[dout_w*32 +: 32] <= reg_wdata;
    end
  end

  // ****************************************
  // Sequencer state
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE, S_GATE, S_CHECK, S_READY, S_RUN, S_PAUSE, S_DONE, S_BLOCK
  } seq_e;
  seq_e        state_reg;
  logic [6:0]  job_reg, job_prev_reg;
  logic [4:0]  step_reg;
  logic [6:0]  rep_reg, bcnt_reg;
  logic [2:0]  stage_reg;
  logic        began_reg, first_reg, fbad_reg, bbad_reg, bdone_reg;
  logic        loosen_reg, locked_reg;
  logic [13:0] sec_reg;
  logic [26:0] sdiv_reg;
  logic [16:0] mdiv_reg;
  logic [15:0] pcnt_reg;

  wire [6:0]  job_num  = ctrl_reg[C_PSEL] ? pin_reg[6:0] : ctrl_reg[6:0];
  wire        job_chg  = job_num != job_prev_reg;
  wire        job_ok   = job_num != 7'h00 && job_num <= 7'(JOBS);
  wire [6:0]  jx       = job_reg - 7'h01;
  wire [11:0] rd_idx   = 12'(jx) * 12'(STEPS) + 12'(step_reg);
  wire [13:0] step_ent = job_mem[rd_idx];
  wire [6:0]  st_ch    = step_ent[13:7];
  wire [6:0]  st_cnt   = step_ent[6:0];
  wire [27:0] jtime    = time_mem[jx];
  wire [7:0]  jflag    = flag_mem[jx];
  wire [1:0]  lmode    = jflag[F_LOOSE +: 2];
  wire        multi    = ctrl_reg[C_MULTI];
  wire        cont     = jflag[F_CONT] & ~mspindle;
  wire [63:0] stg_all  = {stg_hi_reg, stg_lo_reg};
  wire [6:0]  stg_ch   = stg_all[8*stage_reg +: 7];
  wire [6:0]  stg_nx   = stg_all[8*3'(stage_reg + 3'h1) +: 7];
  // Stage list ends at eight or at a zero channel
  wire        st_last  = !multi || stage_reg == 3'(STAGES - 1) || stg_nx == '0;
  wire        step_end = st_ch == '0 || st_cnt == '0 || step_reg >= 5'(STEPS);
  wire [6:0]  btgt     = ctrl_reg[C_SRC +: 2] == SRC_CHAN ? tgt_reg : tgt_ext;
  wire        bat_on   = ctrl_reg[C_SRC +: 2] != SRC_OFF;
  wire        blk_tool = multi && ctrl_reg[C_BLOCK] && bdone_reg;
  wire        auto_go  = cont && !first_reg;
  wire        go       = (start_evt | auto_go) && !loosen_reg
                         && !locked_reg && !blk_tool;
  wire        fin      = state_reg == S_RUN && fasten_done && st_last;
  wire        fgood    = fasten_good && !fbad_reg;
  wire        s_cnt    = fgood || jflag[F_TALLY];
  wire        b_cnt    = bat_on && !bdone_reg && (fgood || ctrl_reg[C_BALL]);
  wire        sec_tick = sdiv_reg == 27'(SEC_CYCLES - 1);
  wire        ms_tick  = mdiv_reg == 17'(MSEC_CYCLES - 1);
  wire        live     = state_reg != S_IDLE && state_reg != S_DONE
                         && state_reg != S_BLOCK;
  wire        t_launch = jtime[13:0] != '0 && !began_reg
                         && sec_reg >= jtime[13:0];
  wire        t_end    = jtime[27:14] != '0 && sec_reg >= jtime[27:14];

  // Time base: the seconds timer restarts on every job selection; the millisecond timer runs free
  always_ff @(posedge clk_sys) begin
    if (!rst_n || job_chg) begin
      sdiv_reg <= '0;
      sec_reg  <= '0;
    end else begin
      sdiv_reg <= sec_tick ? '0 : sdiv_reg + 27'h1;
      if (sec_tick && sec_reg != 14'h3fff) sec_reg <= sec_reg + 14'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) mdiv_reg <= '0;
    else mdiv_reg <= ms_tick ? '0 : mdiv_reg + 17'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg    <= S_IDLE;
      job_reg      <= '0;
      job_prev_reg <= '0;
      step_reg     <= '0;
      rep_reg      <= '0;
      stage_reg    <= '0;
      began_reg    <= 1'b0;
      first_reg    <= 1'b1;
      fbad_reg     <= 1'b0;
      loosen_reg   <= 1'b0;
      locked_reg   <= 1'b0;
      pcnt_reg     <= '0;
      job_invalid  <= 1'b0;
      job_blocked  <= 1'b0;
      pin_prev_reg <= '0;
    end else begin
      pin_prev_reg <= pin_reg;
      job_prev_reg <= job_num;
      // Loosening may run any number of times before the next start
      if (loosen_done) loosen_reg <= 1'b0;
      if (job_chg || release_evt || rise[11] || pin_reg[12] & ~pin_prev_reg[12])
        locked_reg <= 1'b0;
      if (job_chg) begin
        job_reg     <= job_num;
        step_reg    <= '0;
        rep_reg     <= '0;
        stage_reg   <= '0;
        began_reg   <= 1'b0;
        first_reg   <= 1'b1;
        loosen_reg  <= 1'b0;
        job_invalid <= 1'b0;
        job_blocked <= 1'b0;
        state_reg   <= !job_ok ? S_IDLE
                     : flag_mem[7'(job_num - 7'h01)][F_GATE] ? S_GATE : S_CHECK;
      end else if (live && t_launch) begin
        job_invalid <= 1'b1;
        state_reg   <= S_IDLE;
      end else if (live && t_end) begin
        job_blocked <= 1'b1;
        state_reg   <= S_BLOCK;
      end else begin
        unique case (state_reg)
          S_IDLE, S_BLOCK: state_reg <= state_reg;
          S_GATE: if (launch_evt) state_reg <= S_CHECK;
          S_CHECK: state_reg <= step_end ? S_DONE : S_READY;
          S_READY: if (go) begin
            state_reg <= S_RUN;
            began_reg <= 1'b1;
            first_reg <= 1'b0;
            fbad_reg  <= 1'b0;
            stage_reg <= '0;
          end
          S_RUN: if (fasten_done) begin
            if (!fasten_good) fbad_reg <= 1'b1;
            if (!st_last) begin
              pcnt_reg  <= '0;
              stage_reg <= stage_reg + 3'h1;
              state_reg <= ctrl_reg[C_PAUSE] ? S_PAUSE : S_RUN;
            end else begin
              if (!fgood && lmode == LOOSE_FAIL) loosen_reg <= 1'b1;
              if (!cont) first_reg <= 1'b1;
              state_reg <= S_CHECK;
              if (s_cnt && rep_reg + 7'h1 >= st_cnt) begin
                rep_reg  <= '0;
                step_reg <= step_reg + 5'h1;
              end else if (s_cnt) begin
                rep_reg <= rep_reg + 7'h1;
              end
            end
          end
          S_PAUSE: begin
            if (ms_tick) pcnt_reg <= pcnt_reg + 16'h1;
            if (pcnt_reg >= pause_reg[15:0]) state_reg <= S_RUN;
          end
          S_DONE: begin
            if (jflag[F_REPEAT] && !locked_reg) begin
              step_reg  <= '0;
              rep_reg   <= '0;
              first_reg <= 1'b1;
              state_reg <= S_CHECK;
            end
          end
        endcase
        if (state_reg == S_CHECK && step_end && jflag[F_LOCK])
          locked_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // Batch judgment
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n || job_chg) begin
      bcnt_reg          <= '0;
      bbad_reg          <= 1'b0;
      bdone_reg         <= 1'b0;
      batch_good_output <= 1'b0;
      batch_good_lamp   <= 1'b0;
      batch_fail_output <= 1'b0;
    end else if (fin && b_cnt) begin
      bcnt_reg <= bcnt_reg + 7'h1;
      if (!fgood) bbad_reg <= 1'b1;
      if (bcnt_reg + 7'h1 >= btgt) begin
        bdone_reg         <= 1'b1;
        batch_good_output <= fgood && !bbad_reg;
        batch_good_lamp   <= fgood && !bbad_reg;
        batch_fail_output <= !fgood || bbad_reg;
      end
    end
  end

  // ****************************************
  // Engine and result outputs
  // ****************************************
  wire       stg_go = state_reg == S_RUN && fasten_done && !st_last
                      && !ctrl_reg[C_PAUSE];
  wire       pz_go  = state_reg == S_PAUSE && pcnt_reg >= pause_reg[15:0];
  wire [7:0] rec_hit;
  generate
    for (gi = 0; gi < STAGES; gi++) begin : g_rec
      wire [3:0] sel = record_reg[4*gi +: 4];
      assign rec_hit[gi] = state_reg == S_RUN && fasten_done
                           && (sel == 4'(stage_reg) + 4'h1
                               || (sel == 4'h0 && st_last));
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      engine_start   <= 1'b0;
      engine_channel <= '0;
      reverse_cmd    <= 1'b0;
      curve_capture  <= 1'b0;
      data_out_req   <= 1'b0;
      record_strobe  <= '0;
      job_done       <= 1'b0;
    end else begin
      // No launch in the cycle a timeout or job change takes the sequencer
      engine_start   <= ((state_reg == S_READY && go) || stg_go || pz_go)
                        && !t_launch && !t_end && !job_chg;
      engine_channel <= multi ? stg_ch : st_ch;
      reverse_cmd    <= rev_lvl && lmode != LOOSE_DIS;
      curve_capture  <= !multi || curve_reg[stage_reg];
      data_out_req   <= fin && dout_en_reg[st_ch];
      record_strobe  <= rec_hit;
      job_done       <= state_reg == S_DONE;
    end
  end

  // ****************************************
  // Register read-back
  // ****************************************
  wire [31:0] status = {5'h0, loosen_reg, locked_reg, job_blocked,
                        job_invalid, bdone_reg, step_reg, bcnt_reg,
                        state_reg, job_reg};
  wire [31:0] rd_mux =
      reg_addr == A_CTRL   ? ctrl_reg :
      reg_addr == A_BATCH  ? {16'h0, curve_reg, 1'b0, tgt_reg} :
      reg_addr == A_RECORD ? record_reg :
      reg_addr == A_PAUSE  ? pause_reg :
      reg_addr == A_STG_LO ? stg_lo_reg :
      reg_addr == A_STG_HI ? stg_hi_reg :
      reg_addr == A_JADDR  ? {19'h0, ja_step_reg, 1'b0, ja_job_reg} :
      reg_addr == A_JSTEP && ja_ok ? {18'h0, job_mem[wr_idx]} :
      reg_addr == A_JTIME && ja_ok ? {4'h0, time_mem[ja_job_reg]} :
      reg_addr == A_JFLAG && ja_ok ? {24'h0, flag_mem[ja_job_reg]} :
      reg_addr == A_STATUS ? status :
      dout_hit ? dout_en_reg[dout_w*32 +: 32] : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) reg_rdata <= '0;
    else reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end
endmodule

// >>> sim/fjs_props.sv
/*
  Checker for the fastening job sequencer outputs.
  Assumes it is bound to the top module; one clock domain, clk_sys.
*/
`timescale 1ns/1ps
module fjs_props (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Observed ports
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        engine_start,
  input  wire logic        fasten_done,
  input  wire logic        batch_good_output,
  input  wire logic        batch_good_lamp,
  input  wire logic        batch_fail_output,
  input  wire logic        data_out_req,
  input  wire logic [7:0]  record_strobe,
  input  wire logic        job_invalid,
  input  wire logic        job_blocked
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_one_shot;
    engine_start ##1 !engine_start;
  endsequence
  a_start_one_shot: assert property (engine_start |-> s_one_shot)
    else $error("engine start held past one cycle");
  a_verdict_excl: assert property (!(batch_good_output && batch_fail_output))
    else $error("good and fail verdict together");
  a_lamp_follows: assert property (batch_good_lamp == batch_good_output)
    else $error("lamp differs from good output");
  a_rdata_cause: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data without a read");
  a_invalid_quiet: assert property (job_invalid |-> !engine_start)
    else $error("start issued on an invalid job");
  a_blocked_quiet: assert property (job_blocked |-> !engine_start)
    else $error("start issued on a blocked job");
  a_send_cause: assert property (data_out_req |-> $past(fasten_done))
    else $error("result send without a completion");
  a_record_cause: assert property (|record_strobe |-> $past(fasten_done))
    else $error("record strobe without a completion");
endmodule

// >>> sim/engine_model.sv
/*
  Fastening engine stand-in: answers each start with one done pulse.
  Assumes the bench sets judgment and answer delay before each start.
*/
`timescale 1ns/1ps
module engine_model (
  // Clock
  input  wire logic       clk_sys,
  // Stimulus from bench
  input  wire logic       good_in,
  input  wire logic [2:0] dly,
  // Engine link
  input  wire logic       engine_start,
  output logic            fasten_done,
  output logic            fasten_good
);
  // ****************************************
  // Answer timer
  // ****************************************
  int cnt = 0;
  initial fasten_done = 1'b0;
  always @(posedge clk_sys) begin
    fasten_done <= 1'b0;
    if (engine_start) begin
      cnt <= int'(dly) + 1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      fasten_done <= 1'b1;
    end
  end
  // Judgment is only meaningful beside done, so it flips elsewhere
  assign fasten_good = fasten_done ? good_in : ~good_in;
endmodule

// >>> sim/testbench.sv
/*
  Self-checking bench for the fastening job sequencer.
  Assumes the engine model on the engine side and panel jobs via registers.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module testbench;
  import fjs_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, good_in = 1, start_in = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v;
  logic [6:0]  ext_job_num = 7'h00, batch_target_ext = 7'h00, engine_channel, ch;
  logic        seq_launch_in = 0, run_in = 0, reset_in = 0, tool_reset_in = 0;
  logic        id_reentry_in = 0, reverse_req_in = 0, multi_spindle_in = 0, loosen_done = 0;
  logic        engine_start, reverse_cmd, fasten_done, fasten_good, curve_capture;
  logic        batch_good_output, batch_good_lamp, batch_fail_output, data_out_req;
  logic        job_done, job_invalid, job_blocked;
  logic [7:0]  record_strobe;
  logic [2:0]  dly = 3'h1;
  int          failures = 0, compares = 0, cyc = 0, sends = 0;

  fastening_job_sequencer #(.SEC_CYCLES(20), .MSEC_CYCLES(4)) i_dut (.clk_sys, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_job_num, .start_in,
    .seq_launch_in, .run_in, .reset_in, .tool_reset_in, .id_reentry_in, .reverse_req_in,
    .multi_spindle_in, .batch_target_ext, .engine_start, .engine_channel, .reverse_cmd,
    .fasten_done, .fasten_good, .loosen_done, .batch_good_output, .batch_good_lamp,
    .batch_fail_output, .curve_capture, .data_out_req, .record_strobe, .job_done,
    .job_invalid, .job_blocked);
  engine_model i_eng (.clk_sys, .good_in, .dly, .engine_start, .fasten_done, .fasten_good);

  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (data_out_req === 1'b1) sends <= sends + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  // ****************************************
  // Tasks and expectations
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  // Waits on 0 job end, 1 invalid, 2 one fastening; bounded
  task automatic wait_for(input int w);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      #1;
      if ((w == 0 && job_done === 1'b1) || (w == 1 && job_invalid === 1'b1)) break;
      if (w == 2 && fasten_done === 1'b1) break;
    end
  endtask
  // One step of channel c, count n, then a zero step ends the list
  task automatic job(input int j, input int c, input int n, input logic [7:0] fl,
                     input logic [31:0] tm);
    @(posedge clk_sys);
    {run_in, tool_reset_in, id_reentry_in} <= 3'b111;
    repeat (5) @(posedge clk_sys);
    {run_in, tool_reset_in, id_reentry_in} <= 3'b000;
    wr(A_JADDR, 32'(j - 1));
    wr(A_JSTEP, 32'((c << 7) | n));
    wr(A_JADDR, 32'h100 | 32'(j - 1));
    wr(A_JSTEP, 32'h0);
    wr(A_JFLAG, {24'h0, fl});
    wr(A_JTIME, tm);
    wr(A_CTRL, 32'h400 | (32'(fl[0]) << 9) | 32'(j));
    repeat (10) @(posedge clk_sys);
  endtask
  // Returns {good, fail} for judgments g over k fastenings
  function automatic logic [1:0] verdict(input logic [3:0] g, input int k, input bit all,
                                         input int tgt);
    int cnt = 0;
    logic bad = 1'b0;
    for (int i = 0; i < k; i++) begin
      if (all || g[i]) begin
        cnt++;
        bad = bad | !g[i];
      end
    end
    return (cnt < tgt) ? 2'b00 : {!bad, bad};
  endfunction
  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(10193));
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(A_CTRL);
    `CHK("ctrl reset", 32'h0, rd_v)
    rd(A_BATCH);
    `CHK("target reset", 32'h0000ff01, rd_v)
    rd(8'h3c);
    `CHK("unmapped", 32'h0, rd_v)
    `CHK("idle outputs", 3'b000, {batch_good_output, batch_fail_output, job_done})
    $display("test reset values finished");
    ch = 7'(1 + $urandom % 99);
    dly = 3'($urandom);
    ext_job_num <= 7'($urandom);
    batch_target_ext <= 7'($urandom);
    wr(A_BATCH, 32'hff02);
    wr(A_DOUT0 + 8'(4 * (ch >> 5)), 32'h1 << ch[4:0]);
    job(1, ch, 2, 8'h00, 32'h0);
    for (int i = 0; i < 3; i++) begin
      good_in <= (i != 0);
      reverse_req_in <= (i == 2);
      start_in <= 1'b1;
      wait_for(2);
      `CHK("channel", ch, engine_channel)
      `CHK("curve", 1'b1, curve_capture)
      @(posedge clk_sys) start_in <= 1'b0;
      repeat (8) @(posedge clk_sys);
    end
    wait_for(0);
    `CHK("job end", 1'b1, job_done)
    `CHK("ok tally", verdict(4'b0110, 3, 0, 2), {batch_good_output, batch_fail_output})
    `CHK("lamp", 1'b1, batch_good_lamp)
    `CHK("sends", 3, sends)
    `CHK("reverse", 1'b1, reverse_cmd)
    $display("test pass tally finished");
    dly = 3'($urandom);
    job(2, ch, 2, 8'h21, 32'h0);
    good_in <= 1'b0;
    start_in <= 1'b1;
    wait_for(2);
    @(posedge clk_sys);
    good_in <= 1'b1;
    start_in <= 1'b0;
    wait_for(2);
    wait_for(0);
    `CHK("cont end", 1'b1, job_done)
    `CHK("all tally", verdict(4'b0010, 2, 1, 2), {batch_good_output, batch_fail_output})
    `CHK("lamp off", 1'b0, batch_good_lamp)
    $display("test every tally finished");
    job(3, ch, 1, 8'h08, 32'h2);
    repeat (15) @(posedge clk_sys);
    #1;
    `CHK("early invalid", 1'b0, job_invalid)
    `CHK("no reverse", 1'b0, reverse_cmd)
    wait_for(1);
    `CHK("late invalid", 1'b1, job_invalid)
    $display("test launch timeout finished");
    wrap_up();
  end
endmodule
bind fastening_job_sequencer fjs_props i_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .engine_start(engine_start),
  .fasten_done(fasten_done), .batch_good_output(batch_good_output),
  .batch_good_lamp(batch_good_lamp), .batch_fail_output(batch_fail_output),
  .data_out_req(data_out_req), .record_strobe(record_strobe),
  .job_invalid(job_invalid), .job_blocked(job_blocked));
